//--- rtl/msat_core.sv
// saturation read path and accumulate clamp of the multiplier
`timescale 1ns/10ps
`default_nettype none
`include "msat_cfg.svh"

module msat_core (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // datapath side: product loading from the multiply core
  input  wire logic        op_start,
  input  wire logic        op_start_high,
  input  wire logic        op_accumulate,
  input  wire msat_pkg::msat_size_t op_size,
  input  wire logic [63:0] op_product,
  output logic             result_ready
);

  // ==========================================
  // clamp decision shared by read path and accumulate input
  function automatic msat_pkg::msat_clamp_t clamp_kind(
    input logic carry,
    input logic msb,
    input logic frac,
    input logic top1
  );
    msat_pkg::msat_clamp_t k;
    k = msat_pkg::MSAT_CL_NONE;
    if (msb && !carry) k = msat_pkg::MSAT_CL_POS;
    else if (carry && !msb) k = msat_pkg::MSAT_CL_NEG;
    else if (frac && !carry && top1) k = msat_pkg::MSAT_CL_POS;
    else if (frac && carry && !top1) k = msat_pkg::MSAT_CL_NEG;
    return k;
  endfunction

  function automatic logic [63:0] saturate(
    input logic [63:0] v,
    input logic carry,
    input logic wide,
    input logic frac
  );
    msat_pkg::msat_clamp_t k;
    logic [63:0] r;
    r = v;
    if (wide) begin
      k = clamp_kind(carry, v[63], frac, v[62]);
      if (k == msat_pkg::MSAT_CL_POS) r = `MSAT_POS64;
      else if (k == msat_pkg::MSAT_CL_NEG) r = `MSAT_NEG64;
    end else begin
      k = clamp_kind(carry, v[31], frac, v[30]);
      if (k == msat_pkg::MSAT_CL_POS) r = {v[63:32], `MSAT_POS32};
      else if (k == msat_pkg::MSAT_CL_NEG) r = {v[63:32], `MSAT_NEG32};
    end
    return r;
  endfunction

  // ==========================================
  // control and result storage
  logic [3:0]  ctl_r;
  logic [63:0] res_r;
  logic [15:0] sum_extension_r;
  logic [3:0]  lat_r;
  logic        ready_r;
  logic        sat_on;
  logic        frac_on;
  logic        wide_on;

  assign sat_on  = ctl_r[`MSAT_BIT_SAT];
  assign frac_on = ctl_r[`MSAT_BIT_FRAC];
  assign wide_on = ctl_r[`MSAT_BIT_LONG];

  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_fire;
  logic        new_wide;
  logic [63:0] acc_in;
  logic [63:0] sum;
  logic        sum_carry;

  assign wr_fire  = aw_held_r && w_held_r && !s_axi_bvalid;
  assign new_wide = (op_size != msat_pkg::MSAT_SZ_SS);
  // accumulate sees the clamped previous result, fraction ignored
  assign acc_in = sat_on ? saturate(res_r, ctl_r[`MSAT_BIT_CARRY], new_wide, 1'b0)
                         : res_r;
  assign {sum_carry, sum} = op_accumulate ? ({1'b0, acc_in} + {1'b0, op_product})
                                          : {1'b0, op_product};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction
  // control word after a byte-masked write
  logic [31:0] ctl_wr;
  assign ctl_wr = merge({28'h000_0000, ctl_r}, wdata_r, wstrb_r);

  // result words, carry and sum extension; saturation reaches them only through the clamped accumulate input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_r    <= 64'h0000_0000_0000_0000;
      sum_extension_r <= 16'h0000;
      ctl_r    <= `MSAT_RST_CTL;
    end else if (ce) begin
      if (op_start) begin
        res_r                  <= sum;
        ctl_r[`MSAT_BIT_LONG]  <= new_wide;
        ctl_r[`MSAT_BIT_CARRY] <= sum_carry;
        sum_extension_r               <= sum_carry ? 16'hFFFF : 16'h0000;
      end else if (wr_fire) begin
        case (awaddr_r)
          `MSAT_ADDR_CTL: ctl_r <= ctl_wr[3:0];
          `MSAT_ADDR_RAW_LO: res_r[31:0] <= merge(res_r[31:0], wdata_r, wstrb_r);
          `MSAT_ADDR_RAW_HI: res_r[63:32] <= merge(res_r[63:32], wdata_r, wstrb_r);
          default: ;
        endcase
      end
    end
  end

  // ==========================================
  // result availability counter
  logic [3:0] lat_sel;
  always_comb begin
    case (op_size)
      msat_pkg::MSAT_SZ_SS: lat_sel = `MSAT_LAT_SHORT;
      msat_pkg::MSAT_SZ_LS: lat_sel = `MSAT_LAT_MIXED;
      msat_pkg::MSAT_SZ_SL: lat_sel = op_start_high ? `MSAT_LAT_MIXED_HI
                                                    : `MSAT_LAT_MIXED;
      msat_pkg::MSAT_SZ_LL: lat_sel = op_start_high ? `MSAT_LAT_LONG_HI
                                                    : `MSAT_LAT_LONG;
      default: lat_sel = `MSAT_LAT_LONG;
    endcase
  end

  // ready rises lat_sel cycles after the starting write; the read clamp does not wait for it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_r   <= 4'h0;
      ready_r <= 1'b1;
    end else if (ce) begin
      if (op_start) begin
        lat_r   <= lat_sel - 4'h1;
        ready_r <= 1'b0;
      end else if (lat_r != 4'h0) begin
        lat_r <= lat_r - 4'h1;
      end else begin
        ready_r <= 1'b1;
      end
    end
  end
  assign result_ready = ready_r;

  // ==========================================
  // read path: fraction shift then clamp, store left raw
  logic [63:0] rd_view;
  logic [63:0] shifted;
  assign shifted = frac_on ? {res_r[62:0], 1'b0} : res_r;
  // second clamp path through the shared function, kept only to cross-check rd_sat
  assign rd_view = sat_on ? saturate(shifted, ctl_r[`MSAT_BIT_CARRY], wide_on, 1'b0)
                          : shifted;
  logic [63:0] rd_sat;
  always_comb begin
    msat_pkg::msat_clamp_t k;
    k = msat_pkg::MSAT_CL_NONE;
    rd_sat = shifted;
    if (sat_on) begin
      k = wide_on ? clamp_kind(ctl_r[`MSAT_BIT_CARRY], res_r[63], frac_on, res_r[62])
                  : clamp_kind(ctl_r[`MSAT_BIT_CARRY], res_r[31], frac_on, res_r[30]);
      if (wide_on) begin
        if (k == msat_pkg::MSAT_CL_POS) rd_sat = `MSAT_POS64;
        else if (k == msat_pkg::MSAT_CL_NEG) rd_sat = `MSAT_NEG64;
      end else begin
        if (k == msat_pkg::MSAT_CL_POS) rd_sat[31:0] = `MSAT_POS32;
        else if (k == msat_pkg::MSAT_CL_NEG) rd_sat[31:0] = `MSAT_NEG32;
      end
    end
  end

  // ==========================================
  // axi4-lite write channel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MSAT_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_fire && !op_start) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r == `MSAT_ADDR_CTL || awaddr_r == `MSAT_ADDR_RAW_LO ||
                         awaddr_r == `MSAT_ADDR_RAW_HI) ? `MSAT_RESP_OKAY
                                                       : `MSAT_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // a datapath load in the same cycle delays the bus write by one cycle
  assign s_axi_awready = !aw_held_r && ce;
  assign s_axi_wready  = !w_held_r && ce;

  // ==========================================
  // axi4-lite read channel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `MSAT_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `MSAT_RESP_OKAY;
        case (s_axi_araddr)
          `MSAT_ADDR_CTL:    s_axi_rdata <= {28'h000_0000, ctl_r};
          `MSAT_ADDR_RESULT_WORD0:   s_axi_rdata <= {16'h0000, rd_sat[15:0]};
          `MSAT_ADDR_RESULT_WORD1:   s_axi_rdata <= {16'h0000, rd_sat[31:16]};
          `MSAT_ADDR_RESULT_WORD2:   s_axi_rdata <= {16'h0000, rd_sat[47:32]};
          `MSAT_ADDR_RESULT_WORD3:   s_axi_rdata <= {16'h0000, rd_sat[63:48]};
          `MSAT_ADDR_SUM_EXTENSION: s_axi_rdata <= {16'h0000, sum_extension_r};
          `MSAT_ADDR_RAW_LO: s_axi_rdata <= res_r[31:0];
          `MSAT_ADDR_RAW_HI: s_axi_rdata <= res_r[63:32];
          `MSAT_ADDR_STAT:   s_axi_rdata <= {31'h0000_0000, ready_r};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MSAT_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  assign s_axi_arready = !s_axi_rvalid && ce;

  // ==========================================
  // checks
  // both clamp paths must agree whenever the fraction cannot matter
  a_view_match: assert property (@(posedge clk) disable iff (!rst_n)
    (sat_on && !frac_on) |-> rd_sat == rd_view)
    else $error("read clamp paths disagree");

  a_pos_clamp_word: assert property (@(posedge clk) disable iff (!rst_n)
    (sat_on && !wide_on && res_r[31] && !ctl_r[`MSAT_BIT_CARRY])
      |-> rd_sat[31:0] == `MSAT_POS32)
    else $error("short overflow not clamped positive");
  a_neg_clamp_word: assert property (@(posedge clk) disable iff (!rst_n)
    (sat_on && !wide_on && !res_r[31] && ctl_r[`MSAT_BIT_CARRY])
      |-> rd_sat[31:0] == `MSAT_NEG32)
    else $error("short underflow not clamped negative");
  a_sat_off_raw: assert property (@(posedge clk) disable iff (!rst_n)
    !sat_on |-> rd_sat == shifted)
    else $error("clamp active with saturation off");
  a_wide_pos: assert property (@(posedge clk) disable iff (!rst_n)
    (sat_on && wide_on && res_r[63] && !ctl_r[`MSAT_BIT_CARRY]) |-> rd_sat == `MSAT_POS64)
    else $error("wide overflow not clamped");
  a_wide_neg: assert property (@(posedge clk) disable iff (!rst_n)
    (sat_on && wide_on && !res_r[63] && ctl_r[`MSAT_BIT_CARRY]) |-> rd_sat == `MSAT_NEG64)
    else $error("wide underflow not clamped");
  a_store_raw: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !op_start && !wr_fire) |=> $stable(res_r))
    else $error("result store changed without a load");
  a_short_ready: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && op_start && op_size == msat_pkg::MSAT_SZ_SS) ##1 (ce && !op_start) [*3]
      |=> result_ready)
    else $error("short result not ready after three cycles");
  a_long_busy: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && op_start && op_size == msat_pkg::MSAT_SZ_LL && !op_start_high)
      ##1 (ce && !op_start) [*8] |-> !result_ready)
    else $error("long result ready too early");
  // latency checks count idle cycles; a second start inside the window voids them
  a_long_ready: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && op_start && op_size == msat_pkg::MSAT_SZ_LL && op_start_high)
      ##1 (ce && !op_start) [*6] |=> result_ready)
    else $error("long result late after high word");
  a_mixed_busy: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && op_start && op_size == msat_pkg::MSAT_SZ_LS)
      ##1 (ce && !op_start) [*6] |-> !result_ready)
    else $error("mixed result ready too early");
  a_mixed_ready: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && op_start && op_size == msat_pkg::MSAT_SZ_SL && op_start_high)
      ##1 (ce && !op_start) [*4] |=> result_ready)
    else $error("mixed result late after high word");
  a_acc_clamp: assert property (@(posedge clk) disable iff (!rst_n)
    (sat_on && op_accumulate && !new_wide && res_r[31] && !ctl_r[`MSAT_BIT_CARRY])
      |-> acc_in[31:0] == `MSAT_POS32)
    else $error("accumulate input not clamped");
  a_acc_frac_free: assert property (@(posedge clk) disable iff (!rst_n)
    (sat_on && frac_on && !new_wide && !res_r[31] && !ctl_r[`MSAT_BIT_CARRY])
      |-> acc_in == res_r)
    else $error("accumulate input clamped by fraction");
  a_frac_shift: assert property (@(posedge clk) disable iff (!rst_n)
    (frac_on && !sat_on) |-> rd_sat == {res_r[62:0], 1'b0})
    else $error("fractional read not shifted");
  a_frac_pos: assert property (@(posedge clk) disable iff (!rst_n)
    (sat_on && frac_on && !wide_on && !ctl_r[`MSAT_BIT_CARRY] && !res_r[31] && res_r[30])
      |-> rd_sat[31:0] == `MSAT_POS32)
    else $error("fractional overflow not clamped");
  a_short_upper: assert property (@(posedge clk) disable iff (!rst_n)
    (sat_on && !wide_on) |-> rd_sat[63:32] == shifted[63:32])
    else $error("short clamp touched upper words");
  a_sum_extension_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !op_start) |=> $stable(sum_extension_r))
    else $error("sum extension changed without a load");
  // ce low must hold the store, control, latency counter and ready flag, bvalid and rvalid included
  a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    !ce |=> ($stable(res_r) && $stable(ctl_r) && $stable(lat_r) && $stable(ready_r)
             && $stable(s_axi_bvalid) && $stable(s_axi_rvalid)))
    else $error("state moved while clock enable low");
endmodule
`default_nettype wire

//--- rtl/msat_cfg.svh
// constants of the multiplier saturation block
`ifndef MSAT_CFG_SVH
`define MSAT_CFG_SVH
// ==========================================
// register byte addresses
`define MSAT_ADDR_CTL      8'h00
`define MSAT_ADDR_RESULT_WORD0     8'h04
`define MSAT_ADDR_RESULT_WORD1     8'h08
`define MSAT_ADDR_RESULT_WORD2     8'h0C
`define MSAT_ADDR_RESULT_WORD3     8'h10
`define MSAT_ADDR_SUM_EXTENSION   8'h14
`define MSAT_ADDR_RAW_LO   8'h18
`define MSAT_ADDR_RAW_HI   8'h1C
`define MSAT_ADDR_STAT     8'h20
// ==========================================
// control fields
`define MSAT_BIT_SAT       0
`define MSAT_BIT_FRAC      1
`define MSAT_BIT_CARRY     2
`define MSAT_BIT_LONG      3
// ==========================================
// clamp values
`define MSAT_POS32         32'h7FFF_FFFF
`define MSAT_NEG32         32'h8000_0000
`define MSAT_POS64         64'h7FFF_FFFF_FFFF_FFFF
`define MSAT_NEG64         64'h8000_0000_0000_0000
// ==========================================
// result latencies after the operand write, in cycles
`define MSAT_LAT_SHORT     4'h3
`define MSAT_LAT_MIXED     4'h7
`define MSAT_LAT_MIXED_HI  4'h4
`define MSAT_LAT_LONG      4'hB
`define MSAT_LAT_LONG_HI   4'h6
`define MSAT_RESP_OKAY     2'h0
`define MSAT_RESP_SLVERR   2'h2
`define MSAT_RST_CTL       4'h0
`endif

//--- rtl/msat_pkg.sv
// types of the multiplier saturation block
package msat_pkg;
  // operation size classes: first operand x second operand
  typedef enum logic [1:0] {
    MSAT_SZ_SS = 2'b00,
    MSAT_SZ_LS = 2'b01,
    MSAT_SZ_SL = 2'b11,
    MSAT_SZ_LL = 2'b10
  } msat_size_t;
  typedef enum logic [1:0] {
    MSAT_CL_NONE = 2'b00,
    MSAT_CL_POS  = 2'b01,
    MSAT_CL_NEG  = 2'b11
  } msat_clamp_t;
endpackage

//--- sim/msat_dp_model.sv
// datapath-side model that loads products into the saturation block
`timescale 1ns/10ps
`default_nettype none
module msat_dp_model (
  input  wire logic                clk,
  output var  logic                op_start,
  output var  logic                op_start_high,
  output var  logic                op_accumulate,
  output var  msat_pkg::msat_size_t op_size,
  output var  logic [63:0]         op_product
);
  // ==========================================
  // start pulse
  initial begin
    op_start = 1'h0;
    op_start_high = 1'h0;
    op_accumulate = 1'h0;
    op_size = msat_pkg::MSAT_SZ_SS;
    op_product = 64'h0000_0000_0000_0000;
  end
  // size is left standing after the pulse; the read clamp uses the stored width, not op_size
  task automatic launch(input msat_pkg::msat_size_t sz, input logic hi, input logic acc,
                        input logic [63:0] p);
    @(posedge clk);
    op_start <= 1'h1;
    op_start_high <= hi;
    op_accumulate <= acc;
    op_size <= sz;
    op_product <= p;
    @(posedge clk);
    op_start <= 1'h0;
    op_product <= ~p;
  endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
// self-checking bench of the multiplier saturation block
`timescale 1ns/10ps
`default_nettype none
`include "msat_cfg.svh"
module tb;
  localparam logic [1:0]  OK  = `MSAT_RESP_OKAY;
  localparam logic [1:0]  ERR = `MSAT_RESP_SLVERR;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic                 clk, rst_n, ce, awvalid, wvalid, arvalid;
  logic                 awready, wready, bvalid, arready, rvalid;
  logic [7:0]           awaddr, araddr;
  logic [31:0]          wdata, rdata;
  logic [1:0]           bresp, rresp;
  logic                 op_start, op_start_high, op_accumulate, result_ready;
  msat_pkg::msat_size_t op_size;
  logic [63:0]          op_product;
  int                   n_fail, n_tests;
  // ==========================================
  // design and datapath model
  msat_core u_msat_core (.clk(clk), .rst_n(rst_n), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
    .op_start(op_start), .op_start_high(op_start_high), .op_accumulate(op_accumulate),
    .op_size(op_size), .op_product(op_product), .result_ready(result_ready));
  msat_dp_model u_msat_dp_model (.clk(clk), .op_start(op_start),
    .op_start_high(op_start_high), .op_accumulate(op_accumulate),
    .op_size(op_size), .op_product(op_product));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // ==========================================
  // shared tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bready and rready stay high, so each wait ends on the answer itself
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    chk(64'(bresp), 64'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    chk(64'(rdata & m), 64'(e));
    chk(64'(rresp), 64'(er));
  endtask
  task automatic res(input logic [63:0] e, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      rd(8'(`MSAT_ADDR_RESULT_WORD0 + 4 * i), 32'(e[16*i +: 16]), 32'h0000_FFFF, OK);
    end
  endtask
  task automatic pre(input logic [63:0] v, input logic [3:0] c);
    wr(`MSAT_ADDR_RAW_LO, v[31:0], OK);
    wr(`MSAT_ADDR_RAW_HI, v[63:32], OK);
    wr(`MSAT_ADDR_CTL, 32'(c), OK);
  endtask
  task automatic lat(input msat_pkg::msat_size_t sz, input logic hi, input logic acc,
                     input logic [63:0] p, input int n);
    int k;
    k = 0;
    u_msat_dp_model.launch(sz, hi, acc, p);
    #1;
    while (result_ready !== 1'h1 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(64'(k), 64'(n));
    @(posedge clk);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    rd(`MSAT_ADDR_CTL, 32'(`MSAT_RST_CTL), 32'h0000_000F, OK);
    rd(`MSAT_ADDR_STAT, 32'h0000_0001, 32'h0000_0001, OK);
    rd(8'h24, 32'h0000_0000, ALL, ERR);
    wr(8'h24, 32'h0000_1234, ERR);
    wr(`MSAT_ADDR_STAT, 32'h0000_0000, ERR);
  endtask
  task automatic t_sat();
    pre(64'h0000_0000_8000_059F, 4'h0);
    res(64'h0000_0000_8000_059F, 2);
    wr(`MSAT_ADDR_CTL, 32'h0000_0001, OK);
    res(64'h0000_0000_7FFF_FFFF, 2);
    rd(`MSAT_ADDR_RAW_LO, 32'h8000_059F, ALL, OK);
    pre(64'h8000_0000_0000_0000, 4'h9);
    res(64'h7FFF_FFFF_FFFF_FFFF, 4);
    wr(`MSAT_ADDR_CTL, 32'h0000_0001, OK);
    res(64'h8000_0000_0000_0000, 4);
    pre(64'h0000_0000_0000_0000, 4'hD);
    res(64'h8000_0000_0000_0000, 4);
  endtask
  task automatic t_frac();
    pre(64'h0000_0000_4000_0000, 4'h2);
    res(64'h0000_0000_8000_0000, 2);
    rd(`MSAT_ADDR_RAW_LO, 32'h4000_0000, ALL, OK);
    wr(`MSAT_ADDR_CTL, 32'h0000_0003, OK);
    res(64'h0000_0000_7FFF_FFFF, 2);
  endtask
  task automatic t_latency();
    msat_pkg::msat_size_t sz [6];
    logic                 hi [6];
    int                   n  [6];
    sz = '{msat_pkg::MSAT_SZ_SS, msat_pkg::MSAT_SZ_LS, msat_pkg::MSAT_SZ_SL,
           msat_pkg::MSAT_SZ_SL, msat_pkg::MSAT_SZ_LL, msat_pkg::MSAT_SZ_LL};
    hi = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1};
    n = '{`MSAT_LAT_SHORT, `MSAT_LAT_MIXED, `MSAT_LAT_MIXED, `MSAT_LAT_MIXED_HI,
          `MSAT_LAT_LONG, `MSAT_LAT_LONG_HI};
    wr(`MSAT_ADDR_CTL, 32'h0000_0001, OK);
    for (int i = 0; i < 6; i++) begin
      lat(sz[i], hi[i], 1'h0, 64'h0000_0000_0000_0100, n[i]);
    end
  endtask
  task automatic t_accum();
    pre(64'h0000_0000_0000_0000, 4'h5);
    res(64'h0000_0000_8000_0000, 2);
    lat(msat_pkg::MSAT_SZ_SS, 1'h0, 1'h1, 64'hFFFF_FFFF_FFFF_D91E, 3);
    rd(`MSAT_ADDR_RAW_LO, 32'h7FFF_D91E, ALL, OK);
    rd(`MSAT_ADDR_SUM_EXTENSION, 32'h0000_FFFF, ALL, OK);
    wr(`MSAT_ADDR_CTL, 32'h0000_0004, OK);
    wr(`MSAT_ADDR_CTL, 32'h0000_0005, OK);
    rd(`MSAT_ADDR_SUM_EXTENSION, 32'h0000_FFFF, ALL, OK);
    res(64'h0000_0000_8000_0000, 2);
    pre(64'h0000_0000_8000_0000, 4'h9);
    lat(msat_pkg::MSAT_SZ_SS, 1'h0, 1'h1, 64'h0000_0000_0000_0000, 3);
    rd(`MSAT_ADDR_RAW_LO, 32'h7FFF_FFFF, ALL, OK);
    pre(64'h0000_0000_4000_0000, 4'h3);
    lat(msat_pkg::MSAT_SZ_SS, 1'h0, 1'h1, 64'h0000_0000_0000_0000, 3);
    rd(`MSAT_ADDR_RAW_LO, 32'h4000_0000, ALL, OK);
  endtask
  // a start while ce is low must leave the store and the ready flag alone
  task automatic t_hold();
    pre(64'h0000_0000_1234_5678, 4'h0);
    ce <= 1'h0;
    u_msat_dp_model.launch(msat_pkg::MSAT_SZ_LL, 1'h0, 1'h0, 64'h0000_0000_0000_0001);
    @(posedge clk);
    ce <= 1'h1;
    rd(`MSAT_ADDR_RAW_LO, 32'h1234_5678, ALL, OK);
    rd(`MSAT_ADDR_STAT, 32'h0000_0001, 32'h0000_0001, OK);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    n_fail = 0;
    n_tests = 0;
    rst_n = 1'h0;
    ce = 1'h1;
    {awvalid, wvalid, arvalid} = 3'h0;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_sat();
    t_frac();
    t_latency();
    t_accum();
    t_hold();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
